// ---- logic/sro_top.sv ----
// Function
// - Word mode holds one command text, bit mode holds an on text and an off text.
// - A message older than the configured age limit, in 5 min, 30 min, day or week steps, is ignored.
// - An asterisk ends the stored number as a wildcard, and a lone asterisk accepts any sender.
// - Without wildcard the match is exact, and a wildcard needs at least one more character.
// - A shared 4-digit password is checked.
// - While running the reply is OK when the command was processed and Error otherwise.
// - While running the reply is No access for a wrong sender or a wrong or missing password.
// - With retention set, the output states are restored at power-up.
// - In word mode a value above the maximum becomes the maximum.
// - In word mode a value below the minimum becomes the minimum.
// - In bit mode the on text sets the bit flag and the off text clears it.
// - In bit mode idle clears the bit flag over gating, and gating low holds it.
// - In word mode a valid value after the equals sign loads the numeric output.
// - In word mode idle clears the numeric output over gating, and gating low holds it.
`timescale 1ns/10ps
module sro_top (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rst,
   input  wire logic [sro_pkg::ADDR_W-1:0]    i_reg_addr,
   input  wire logic [sro_pkg::DATA_W-1:0]    i_reg_wdata,
   input  wire logic                          i_reg_wr,
   input  wire logic                          i_reg_rd,
   output logic      [sro_pkg::DATA_W-1:0]    o_reg_rdata,
   input  wire logic                          i_tok_valid,
   input  wire sro_pkg::sro_tok_e             i_tok_kind,
   input  wire logic [sro_pkg::CHAR_W-1:0]    i_tok_char,
   input  wire logic [sro_pkg::AGE_W-1:0]     i_msg_age,
   input  wire logic                          i_gating_input,
   input  wire logic                          i_idle_input,
   input  wire logic                          i_restore_valid,
   input  wire logic                          i_restore_bit,
   input  wire logic [15:0]                   i_restore_word,
   output logic                               o_bit_flag,
   output logic      [15:0]                   o_numeric_output,
   output logic                               o_reply_valid,
   output sro_pkg::sro_reply_e                o_reply_code,
   output logic                               o_retain_flag
);
   import sro_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_SENDER, ST_TEXT} sro_state_e;

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [CHAR_W-1:0] byte_at(input logic [DATA_W-1:0] w, input logic [7:0] idx);
      byte_at = (idx < 8'(TEXT_BYTES)) ? w[8*idx[1:0] +: 8] : CH_NUL;
   endfunction

   function automatic logic [7:0] text_len(input logic [DATA_W-1:0] w);
      logic done;
      text_len = 8'(TEXT_BYTES);
      done = 1'b0;
      for (int k = 0; k < TEXT_BYTES; k++) begin
         if (!done && w[8*k +: 8] == CH_NUL) begin
            text_len = 8'(k);
            done = 1'b1;
         end
      end
   endfunction

   // ************************************************************
   // Registers
   // ************************************************************
   logic [DATA_W-1:0] ctrl_reg, pw_reg, on_text_reg, off_text_reg;
   logic [15:0]       max_reg, min_reg;
   sro_reply_e        last_code_reg;
   sro_state_e        state_reg;
   logic              word_mode, ack_en, pw_prot;
   logic [1:0]        age_unit;
   logic [13:0]       age_step;
   logic [AGE_W-1:0]  age_limit;
   sro_mem_if         mem_bus ();

   assign word_mode = ctrl_reg[CTRL_WORD_MODE];
   assign ack_en    = ctrl_reg[CTRL_ACK];
   assign pw_prot   = ctrl_reg[CTRL_PW_PROT];
   assign age_unit  = ctrl_reg[CTRL_UNIT_LSB +: 2];

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ctrl_reg     <= CTRL_RST;
         pw_reg       <= PASSWORD_RST;
         on_text_reg  <= TEXT_RST;
         off_text_reg <= TEXT_RST;
         max_reg      <= MAX_RST;
         min_reg      <= MIN_RST;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            OFS_CTRL:     ctrl_reg     <= i_reg_wdata;
            OFS_PASSWORD: pw_reg       <= i_reg_wdata;
            OFS_ON_TEXT:  on_text_reg  <= i_reg_wdata;
            OFS_OFF_TEXT: off_text_reg <= i_reg_wdata;
            OFS_MAX:      max_reg      <= i_reg_wdata[15:0];
            OFS_MIN:      min_reg      <= i_reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // Number characters go to the memory, one per word
   assign mem_bus.wr_en   = i_reg_wr && (i_reg_addr >= OFS_NUMBER) && (i_reg_addr[1:0] == 2'h0)
                            && (i_reg_addr < OFS_NUMBER + 8'(4 * NUM_DEPTH));
   assign mem_bus.wr_addr = NUM_IDX_W'((i_reg_addr - OFS_NUMBER) >> 2);
   assign mem_bus.wr_data = i_reg_wdata[CHAR_W-1:0];

   sro_num_mem #(.DEPTH(NUM_DEPTH)) u_num_mem (
      .i_sys_clk (i_sys_clk),
      .mem_port  (mem_bus.mem)
   );

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            OFS_CTRL:     o_reg_rdata <= ctrl_reg;
            OFS_PASSWORD: o_reg_rdata <= pw_reg;
            OFS_ON_TEXT:  o_reg_rdata <= on_text_reg;
            OFS_OFF_TEXT: o_reg_rdata <= off_text_reg;
            OFS_MAX:      o_reg_rdata <= {16'h0000, max_reg};
            OFS_MIN:      o_reg_rdata <= {16'h0000, min_reg};
            OFS_STATUS:   o_reg_rdata <= {12'h000, state_reg != ST_IDLE, last_code_reg, o_bit_flag, o_numeric_output};
            default:      o_reg_rdata <= '0;
         endcase
      end else begin
         o_reg_rdata <= '0;
      end
   end

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] gate_sync_reg, idle_sync_reg;
   logic       gate_s, idle_s;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         gate_sync_reg <= 2'h0;
         idle_sync_reg <= 2'h0;
      end else begin
         gate_sync_reg <= {gate_sync_reg[0], i_gating_input};
         idle_sync_reg <= {idle_sync_reg[0], i_idle_input};
      end
   end
   assign gate_s = gate_sync_reg[1];
   assign idle_s = idle_sync_reg[1];

   // ************************************************************
   // Token stage, aligned with the number memory read
   // ************************************************************
   logic              tok_v_reg;
   sro_tok_e          tok_kind_reg;
   logic [CHAR_W-1:0] tok_char_reg;
   logic [AGE_W-1:0]  age_reg;
   logic [NUM_IDX_W-1:0] snd_idx_reg;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         tok_v_reg    <= 1'b0;
         tok_kind_reg <= SRO_TOK_START;
         tok_char_reg <= CH_NUL;
         age_reg      <= '0;
      end else begin
         tok_v_reg    <= i_tok_valid;
         tok_kind_reg <= i_tok_kind;
         tok_char_reg <= i_tok_char;
         age_reg      <= i_msg_age;
      end
   end
   always_comb begin
      case (age_unit)
         2'h0:    age_step = AGE_STEP_5MIN;
         2'h1:    age_step = AGE_STEP_30MIN;
         2'h2:    age_step = AGE_STEP_DAY;
         default: age_step = AGE_STEP_WEEK;
      endcase
   end
   assign age_limit = AGE_W'(ctrl_reg[CTRL_CNT_LSB +: CTRL_CNT_W]) * AGE_W'(age_step);

   // ************************************************************
   // Message parser
   // ************************************************************
   logic       snd_ok_reg, wild_reg, age_ok_reg, pw_ok_reg, on_ok_reg, off_ok_reg;
   logic       eq_reg, neg_reg, digit_reg, val_bad_reg;
   logic [7:0] pos_reg;
   logic [16:0] acc_reg;
   logic       tk_snd, tk_snd_end, tk_txt, tk_end;
   logic [7:0] pw_off, cp, on_len, off_len;
   logic [CHAR_W-1:0] mc, c;
   logic [20:0] acc_mul;

   assign tk_snd     = tok_v_reg && tok_kind_reg == SRO_TOK_SENDER && state_reg == ST_SENDER;
   assign tk_snd_end = tok_v_reg && tok_kind_reg == SRO_TOK_SENDER_END && state_reg == ST_SENDER;
   assign tk_txt     = tok_v_reg && tok_kind_reg == SRO_TOK_TEXT && state_reg == ST_TEXT;
   assign tk_end     = tok_v_reg && tok_kind_reg == SRO_TOK_END && state_reg == ST_TEXT;
   // Read address runs one ahead so the stored character meets the sender character
   assign mem_bus.rd_addr = (tok_v_reg && tok_kind_reg == SRO_TOK_START) ? '0 :
                            ((tk_snd && snd_idx_reg != NUM_IDX_W'(NUM_DEPTH)) ? snd_idx_reg + 1'b1 : snd_idx_reg);
   assign mc         = mem_bus.rd_data;
   assign c          = tok_char_reg;
   assign pw_off     = pw_prot ? 8'(PW_DIGITS) : 8'h00;
   assign cp         = pos_reg - pw_off;
   assign on_len     = text_len(on_text_reg);
   assign off_len    = text_len(off_text_reg);
   assign acc_mul    = 21'(acc_reg * 4'ha) + 21'(c - CH_0);

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
      end else if (tok_v_reg && tok_kind_reg == SRO_TOK_START) begin
         state_reg <= ST_SENDER;
      end else begin
         case (state_reg)
            ST_SENDER: if (tk_snd_end) state_reg <= ST_TEXT;
            ST_TEXT:   if (tk_end) state_reg <= ST_IDLE;
            default:   state_reg <= state_reg;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || (tok_v_reg && tok_kind_reg == SRO_TOK_START)) begin
         snd_idx_reg <= '0;
         snd_ok_reg  <= 1'b1;
         wild_reg    <= 1'b0;
      end else if (tk_snd) begin
         if (snd_idx_reg != NUM_IDX_W'(NUM_DEPTH)) snd_idx_reg <= snd_idx_reg + 1'b1;
         if (!wild_reg && mc == CH_STAR) wild_reg <= 1'b1;
         else if (!wild_reg && mc != c) snd_ok_reg <= 1'b0;
      end else if (tk_snd_end && !wild_reg && mc != CH_NUL) begin
         snd_ok_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         age_ok_reg <= 1'b0;
      end else if (tok_v_reg && tok_kind_reg == SRO_TOK_START) begin
         age_ok_reg <= age_reg <= age_limit;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || (tok_v_reg && tok_kind_reg == SRO_TOK_START)) begin
         pos_reg     <= 8'h00;
         pw_ok_reg   <= 1'b1;
         on_ok_reg   <= 1'b1;
         off_ok_reg  <= 1'b1;
         eq_reg      <= 1'b0;
         neg_reg     <= 1'b0;
         digit_reg   <= 1'b0;
         val_bad_reg <= 1'b0;
         acc_reg     <= '0;
      end else if (tk_txt) begin
         if (pos_reg != 8'hff) pos_reg <= pos_reg + 1'b1;
         if (pos_reg < pw_off) begin
            if (c != byte_at(pw_reg, pos_reg)) pw_ok_reg <= 1'b0;
         end else begin
            if (cp < on_len) begin
               if (c != byte_at(on_text_reg, cp)) on_ok_reg <= 1'b0;
            end else if (!word_mode) begin
               on_ok_reg <= 1'b0;
            end
            if (cp >= off_len || c != byte_at(off_text_reg, cp)) off_ok_reg <= 1'b0;
            if (word_mode && cp >= on_len) begin
               if (cp == on_len) begin
                  if (c == CH_EQ) eq_reg <= 1'b1;
                  else val_bad_reg <= 1'b1;
               end else if (cp == on_len + 8'h01 && c == CH_MINUS) begin
                  neg_reg <= 1'b1;
               end else if (c >= CH_0 && c <= CH_9) begin
                  digit_reg <= 1'b1;
                  acc_reg   <= (acc_mul > 21'h1ffff) ? 17'h1ffff : acc_mul[16:0];
               end else begin
                  val_bad_reg <= 1'b1;
               end
            end
         end
      end
   end

   // ************************************************************
   // Decision at message end
   // ************************************************************
   logic        process, auth, cmd_on, cmd_off, cmd_word, cmd_ok, pass;
   logic        apply_on, apply_off, apply_word, reply_fire;
   logic signed [17:0] val, vmax, vmin;
   logic [15:0] clamped;
   sro_reply_e  reply_code;

   assign process  = tk_end && gate_s;
   assign auth     = snd_ok_reg && (!pw_prot || (pw_ok_reg && pos_reg >= pw_off));
   assign cmd_on   = !word_mode && on_ok_reg && on_len != 8'h00 && pos_reg == pw_off + on_len;
   assign cmd_off  = !word_mode && off_ok_reg && off_len != 8'h00 && pos_reg == pw_off + off_len;
   assign cmd_word = word_mode && on_ok_reg && eq_reg && digit_reg && !val_bad_reg;
   assign cmd_ok   = cmd_on || cmd_off || cmd_word;
   assign pass     = process && age_ok_reg && auth;
   assign apply_on   = pass && cmd_on;
   assign apply_off  = pass && cmd_off && !cmd_on;
   assign apply_word = pass && cmd_word;
   assign reply_fire = process && age_ok_reg && ack_en;
   assign reply_code = !auth ? SRO_REPLY_NO_ACCESS : (cmd_ok ? SRO_REPLY_OK : SRO_REPLY_ERROR);

   assign val  = neg_reg ? -$signed({1'b0, acc_reg}) : $signed({1'b0, acc_reg});
   assign vmax = 18'(signed'(max_reg));
   assign vmin = 18'(signed'(min_reg));
   assign clamped = (val > vmax) ? max_reg : ((val < vmin) ? min_reg : val[15:0]);

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_bit_flag       <= 1'b0;
         o_numeric_output <= 16'h0000;
      end else if (idle_s) begin
         o_bit_flag       <= 1'b0;
         o_numeric_output <= 16'h0000;
      end else if (i_restore_valid && ctrl_reg[CTRL_RETAIN]) begin
         o_bit_flag       <= i_restore_bit;
         o_numeric_output <= i_restore_word;
      end else if (apply_on) begin
         o_bit_flag <= 1'b1;
      end else if (apply_off) begin
         o_bit_flag <= 1'b0;
      end else if (apply_word) begin
         o_numeric_output <= clamped;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_reply_valid <= 1'b0;
         o_reply_code  <= SRO_REPLY_NONE;
         last_code_reg <= SRO_REPLY_NONE;
         o_retain_flag <= 1'b0;
      end else begin
         o_reply_valid <= reply_fire;
         o_retain_flag <= ctrl_reg[CTRL_RETAIN];
         if (reply_fire) o_reply_code <= reply_code;
         if (process && age_ok_reg) last_code_reg <= reply_code;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_idle_bit_clear: assert property (idle_s |=> !o_bit_flag)
      else $error("bit flag not cleared by idle");
   a_idle_word_clear: assert property (idle_sync_reg[0] ##1 idle_s |=> o_numeric_output == 16'h0000)
      else $error("numeric output not cleared by idle");
   a_gate_low_hold: assert property (!gate_s && !idle_s && !i_restore_valid |=> $stable(o_bit_flag) && $stable(o_numeric_output))
      else $error("output changed while gating low");
   a_reject_hold: assert property (tk_end && !(age_ok_reg && auth) && !idle_s && !i_restore_valid |=> $stable(o_bit_flag) && $stable(o_numeric_output))
      else $error("output changed by rejected message");
   a_word_in_range: assert property (apply_word && !idle_s && !i_restore_valid |=> $signed(o_numeric_output) <= $signed($past(max_reg)) && $signed(o_numeric_output) >= $signed($past(min_reg)))
      else $error("word output outside limits");
   a_word_clamp_low: assert property (apply_word && val < vmin && !idle_s && !i_restore_valid |=> o_numeric_output == $past(min_reg))
      else $error("low clamp wrong");
   a_bit_on_set: assert property (apply_on && !idle_s && !i_restore_valid |=> o_bit_flag)
      else $error("bit flag not set by on text");
   a_age_silent: assert property (tk_end && !age_ok_reg |=> !o_reply_valid)
      else $error("reply sent for old message");
   a_no_access: assert property (tk_end && gate_s && age_ok_reg && ack_en && !snd_ok_reg |=> o_reply_valid && o_reply_code == SRO_REPLY_NO_ACCESS)
      else $error("no access reply missing");
   a_reply_needs_ack: assert property (o_reply_valid |-> $past(ack_en) && $past(gate_s))
      else $error("reply without acknowledge enabled");

   c_bit_on: cover property (apply_on ##1 o_bit_flag);
   c_word_clamp: cover property (apply_word && val > vmax);
   c_wild_match: cover property (wild_reg && tk_end && snd_ok_reg);
   c_no_access: cover property (o_reply_valid && o_reply_code == SRO_REPLY_NO_ACCESS);
endmodule // sro_top

// ---- common/sro_pkg.sv ----
package sro_pkg;
   // ************************************************************
   // Widths and sizes
   // ************************************************************
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int CHAR_W     = 8;
   localparam int NUM_DEPTH  = 28;
   localparam int NUM_IDX_W  = 5;
   localparam int AGE_W      = 22;
   localparam int PW_DIGITS  = 4;
   localparam int TEXT_BYTES = 4;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PASSWORD = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ON_TEXT  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_OFF_TEXT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_MAX      = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MIN      = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_NUMBER   = 8'h40;

   // ************************************************************
   // Control and status field positions
   // ************************************************************
   localparam int CTRL_WORD_MODE = 0;
   localparam int CTRL_ACK       = 1;
   localparam int CTRL_RETAIN    = 2;
   localparam int CTRL_PW_PROT   = 3;
   localparam int CTRL_UNIT_LSB  = 4;
   localparam int CTRL_CNT_LSB   = 6;
   localparam int CTRL_CNT_W     = 8;
   localparam int STAT_BIT_POS   = 16;
   localparam int STAT_CODE_LSB  = 17;
   localparam int STAT_BUSY_POS  = 19;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [DATA_W-1:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [DATA_W-1:0] PASSWORD_RST = 32'h3030_3030;
   localparam logic [DATA_W-1:0] TEXT_RST     = 32'h0000_0000;
   localparam logic [15:0]       MAX_RST      = 16'h7fff;
   localparam logic [15:0]       MIN_RST      = 16'h8000;

   // ************************************************************
   // Age steps in minutes
   // ************************************************************
   localparam logic [13:0] AGE_STEP_5MIN  = 14'h0005;
   localparam logic [13:0] AGE_STEP_30MIN = 14'h001e;
   localparam logic [13:0] AGE_STEP_DAY   = 14'h05a0;
   localparam logic [13:0] AGE_STEP_WEEK  = 14'h2760;

   // ************************************************************
   // Characters
   // ************************************************************
   localparam logic [CHAR_W-1:0] CH_NUL   = 8'h00;
   localparam logic [CHAR_W-1:0] CH_STAR  = 8'h2a;
   localparam logic [CHAR_W-1:0] CH_MINUS = 8'h2d;
   localparam logic [CHAR_W-1:0] CH_EQ    = 8'h3d;
   localparam logic [CHAR_W-1:0] CH_0     = 8'h30;
   localparam logic [CHAR_W-1:0] CH_9     = 8'h39;

   typedef enum logic [2:0] {
      SRO_TOK_START,
      SRO_TOK_SENDER,
      SRO_TOK_SENDER_END,
      SRO_TOK_TEXT,
      SRO_TOK_END
   } sro_tok_e;

   typedef enum logic [1:0] {
      SRO_REPLY_NONE,
      SRO_REPLY_OK,
      SRO_REPLY_ERROR,
      SRO_REPLY_NO_ACCESS
   } sro_reply_e;
endpackage

// ---- common/sro_mem_if.sv ----
`timescale 1ns/10ps
interface sro_mem_if;
   import sro_pkg::*;
   logic                 wr_en;
   logic [NUM_IDX_W-1:0] wr_addr;
   logic [CHAR_W-1:0]    wr_data;
   logic [NUM_IDX_W-1:0] rd_addr;
   logic [CHAR_W-1:0]    rd_data;
   modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface // sro_mem_if

// ---- logic/sro_num_mem.sv ----
`timescale 1ns/10ps
module sro_num_mem #(
   parameter int DEPTH = sro_pkg::NUM_DEPTH
) (
   input wire logic i_sys_clk,
   sro_mem_if.mem   mem_port
);
   import sro_pkg::*;

   logic [CHAR_W-1:0] mem_reg [DEPTH];

   always_ff @(posedge i_sys_clk) begin
      if (mem_port.wr_en && (int'(mem_port.wr_addr) < DEPTH)) begin
         mem_reg[mem_port.wr_addr] <= mem_port.wr_data;
      end
   end

   // Past the end reads as terminator
   always_ff @(posedge i_sys_clk) begin
      if (int'(mem_port.rd_addr) < DEPTH) begin
         mem_port.rd_data <= mem_reg[mem_port.rd_addr];
      end else begin
         mem_port.rd_data <= CH_NUL;
      end
   end
endmodule // sro_num_mem

// ---- verification/sro_modem_model.sv ----
`timescale 1ns/10ps
module sro_modem_model (
   input  wire logic         i_sys_clk,
   output logic              o_tok_valid,
   output sro_pkg::sro_tok_e o_tok_kind,
   output logic [7:0]        o_tok_char,
   output logic [21:0]       o_msg_age
);
   import sro_pkg::*;
   initial begin
      o_tok_valid = 1'b0;
      o_tok_kind  = SRO_TOK_START;
      o_tok_char  = 8'h00;
      o_msg_age   = 22'h0;
   end
   task automatic tok(input sro_tok_e k, input logic [7:0] c);
      @(posedge i_sys_clk);
      o_tok_valid <= 1'b1;
      o_tok_kind  <= k;
      o_tok_char  <= c;
   endtask
   // Between messages the character and age lines show a changing pattern
   task automatic send(input string s, input string t, input int age);
      tok(SRO_TOK_START, 8'h00);
      o_msg_age <= age[21:0];
      foreach (s[i]) tok(SRO_TOK_SENDER, s[i]);
      tok(SRO_TOK_SENDER_END, 8'h00);
      foreach (t[i]) tok(SRO_TOK_TEXT, t[i]);
      tok(SRO_TOK_END, 8'h00);
      @(posedge i_sys_clk);
      o_tok_valid <= 1'b0;
      o_tok_char  <= ~o_tok_char;
      o_msg_age   <= ~o_msg_age;
   endtask
endmodule // sro_modem_model

// ---- verification/sro_top_tb.sv ----
`timescale 1ns/10ps
module sro_top_tb;
   import sro_pkg::*;
   logic        clk = 0, rst = 1, wr = 0, rd = 0, gate = 0, idle = 0, word_mode = 0, rest_v = 0;
   logic [15:0] rest_w = 16'h0;
   logic [7:0]  addr = 8'h00, tc;
   logic [31:0] wdata = 32'h0, rdata;
   logic        tv, rv, bitf, rf;
   sro_tok_e    tk;
   sro_reply_e  rc;
   logic [21:0] age;
   logic [15:0] num;
   logic [17:0] notes[$];
   int          failures = 0, cmp_count = 0, cyc = 0, seed = 32'h9b1f, v;
   initial forever #12.5 clk = ~clk;
   sro_modem_model i_modem (.i_sys_clk(clk), .o_tok_valid(tv), .o_tok_kind(tk), .o_tok_char(tc), .o_msg_age(age));
   sro_top i_dut (.i_sys_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .i_tok_valid(tv), .i_tok_kind(tk), .i_tok_char(tc), .i_msg_age(age),
      .i_gating_input(gate), .i_idle_input(idle), .i_restore_valid(rest_v), .i_restore_bit(rest_v),
      .i_restore_word(rest_w), .o_bit_flag(bitf), .o_numeric_output(num), .o_reply_valid(rv),
      .o_reply_code(rc), .o_retain_flag(rf));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, e);
   endtask
   // A reply code of none means the message must be ignored
   task msg(input string s, input string t, input int a, input sro_reply_e c, input logic [15:0] val);
      if (c != SRO_REPLY_NONE) notes.push_back({c, val});
      i_modem.send(s, t, a);
      repeat (4) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         failures++;
         test_done;
      end
   end
   always @(posedge clk) if (rv === 1'b1) check({rc, word_mode ? num : {15'h0, bitf}}, notes.pop_front());
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(OFS_CTRL, CTRL_RST);
      rd_chk(8'h30, 32'h0);
      rd_chk(OFS_NUMBER, 32'h0);
      wr_reg(OFS_CTRL, 32'h82);
      wr_reg(OFS_ON_TEXT, 32'h4e4f);
      wr_reg(OFS_OFF_TEXT, 32'h464f);
      wr_reg(8'h40, 32'h31);
      wr_reg(8'h44, 32'h32);
      wr_reg(8'h48, 32'h2a);
      wr_reg(8'h4c, 32'h0);
      gate <= 1'b1;
      repeat (3) @(posedge clk);
      msg("123", "ON", 10, SRO_REPLY_OK, 16'h1);
      msg("12", "OF", 10, SRO_REPLY_NO_ACCESS, 16'h1);
      msg("124", "OF", 11, SRO_REPLY_NONE, 16'h0);
      msg("125", "XX", 0, SRO_REPLY_ERROR, 16'h1);
      msg("125", "OF", 10, SRO_REPLY_OK, 16'h0);
      word_mode <= 1'b1;
      wr_reg(OFS_CTRL, 32'h8b);
      wr_reg(OFS_PASSWORD, 32'h3433_3231);
      wr_reg(OFS_ON_TEXT, 32'h56);
      wr_reg(OFS_MAX, 32'h64);
      wr_reg(OFS_MIN, 32'hfffb);
      wr_reg(8'h40, 32'h2a);
      wr_reg(8'h44, 32'h0);
      msg("5", "1234V=150", 0, SRO_REPLY_OK, 16'h0064);
      msg("5", "1234V=-9", 0, SRO_REPLY_OK, 16'hfffb);
      msg("5", "1233V=7", 0, SRO_REPLY_NO_ACCESS, 16'hfffb);
      for (int i = 0; i < 3; i++) begin
         v = $unsigned($random(seed)) % 95 - 5;
         msg("9", $sformatf("1234V=%0d", v), 0, SRO_REPLY_OK, v[15:0]);
      end
      gate <= 1'b0;
      repeat (3) @(posedge clk);
      msg("5", "1234V=3", 0, SRO_REPLY_NONE, 16'h0);
      check(num, v[15:0]);
      idle <= 1'b1;
      repeat (5) @(posedge clk);
      check(num, 32'h0);
      check(notes.size(), 0);
      idle <= 1'b0;
      wr_reg(OFS_CTRL, 32'h8d);
      repeat (3) @(posedge clk);
      rest_v <= 1'b1;
      rest_w <= 16'h1234;
      @(posedge clk);
      rest_v <= 1'b0;
      repeat (2) @(posedge clk);
      check(num, 32'h1234);
      check(bitf, 32'h1);
      check(rf, 32'h1);
      test_done;
   end
endmodule // sro_top_tb
